// ===== design/epc_pkg.sv
package epc_pkg;
  localparam int NUM_PERIPH    = 32;
  localparam int NUM_GP        = 9;
  localparam int NUM_LEVELS    = 16;
  localparam int LVL_W         = 4;
  localparam int MAP_W         = 4;
  localparam int ADDR_W        = 32;
  localparam int STATE_W       = 32;
  localparam int GP_BASE       = 7;
  localparam int SW_LVL_LO     = 14;
  localparam logic [3:0] LVL_EMU = 4'h0;
  localparam logic [3:0] LVL_RST = 4'h1;
  localparam logic [3:0] LVL_NMI = 4'h2;
  localparam logic [3:0] LVL_EXC = 4'h3;
  localparam logic [3:0] LVL_HWE = 4'h5;
  localparam logic [3:0] LVL_TMR = 4'h6;
  localparam logic [1:0] SAVE_CYCLES = 2'h2;
  localparam logic [15:0] ACTIVE_RST = 16'h0000;
  localparam logic [3:0] MAP_RST = 4'h0;

  typedef enum logic [2:0] {
    EPC_IDLE,
    EPC_SAVE,
    EPC_ENTER,
    EPC_RESET
  } epc_fsm_t;

  function automatic logic [MAP_W-1:0] epc_default_map(input int src);
    if (src < 14) return 4'h0;
    else if (src < 16) return 4'h1;
    else if (src < 20) return 4'h2;
    else if (src < 26) return 4'h3;
    else if (src < 32) return 4'h4;
    else return 4'h5;
  endfunction
endpackage

// ===== design/epc_route_if.sv
`timescale 1ns/100ps
interface epc_route_if;
  import epc_pkg::*;
  logic [NUM_GP-1:0] gpReq;
  modport stage (output gpReq);
  modport core  (input gpReq);
endinterface

// ===== design/epc_sys_stage.sv
`timescale 1ns/100ps
module epc_sys_stage (
  input  wire logic                       sys_clk,
  input  wire logic                       srst,
  input  wire logic                       clkEn,
  input  wire logic [epc_pkg::NUM_PERIPH-1:0] periphIrq,
  input  wire logic                       mapWrEn,
  input  wire logic [4:0]                 mapWrIdx,
  input  wire logic [epc_pkg::MAP_W-1:0]  mapWrVal,
  epc_route_if.stage                      route
);
  import epc_pkg::*;

  typedef struct packed {
    logic [NUM_PERIPH-1:0][MAP_W-1:0] assign_;
    logic [NUM_GP-1:0]                gp;
  } epc_sys_st_t;

  epc_sys_st_t st_r;
  epc_sys_st_t st_nxt;

  // interrupt_assignment_regs steer each source to a level, or to none for a value of 9 or more; default map at reset
  always_comb begin
    st_nxt = st_r;
    st_nxt.gp = '0;
    for (int s = 0; s < NUM_PERIPH; s++) begin
      if (periphIrq[s] && st_r.assign_[s] < MAP_W'(NUM_GP))
        st_nxt.gp[st_r.assign_[s]] = 1'b1;
    end
    if (mapWrEn)
      st_nxt.assign_[mapWrIdx] = mapWrVal;
    if (srst) begin
      for (int s = 0; s < NUM_PERIPH; s++)
        st_nxt.assign_[s] = epc_default_map(s);
      st_nxt.gp = '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (clkEn || srst)
      st_r <= st_nxt;
  end

  assign route.gpReq = st_r.gp;
endmodule

// ===== design/epc_core_stage.sv
`timescale 1ns/100ps
module epc_core_stage (
  input  wire logic                      sys_clk,
  input  wire logic                      srst,
  input  wire logic                      clkEn,
  input  wire logic [epc_pkg::NUM_LEVELS-1:0] levelReq,
  input  wire logic                      retValid,
  input  wire logic [epc_pkg::LVL_W-1:0] retLevel,
  output logic      [epc_pkg::NUM_LEVELS-1:0] pend,
  output logic      [epc_pkg::NUM_LEVELS-1:0] active,
  output logic                           take,
  output logic      [epc_pkg::LVL_W-1:0] takeLevel
);
  import epc_pkg::*;

  logic [NUM_LEVELS-1:0] pend_r;
  logic [NUM_LEVELS-1:0] pend_nxt;
  logic [NUM_LEVELS-1:0] active_r;
  logic [NUM_LEVELS-1:0] active_nxt;
  logic                  win;
  logic [LVL_W-1:0]      winLvl;
  logic                  blocked;

  // highest urgency pending level; lower number wins
  always_comb begin
    win = 1'b0;
    winLvl = '0;
    for (int i = NUM_LEVELS-1; i >= 0; i--) begin
      if (pend_r[i]) begin
        win = 1'b1;
        winLvl = LVL_W'(i);
      end
    end
    blocked = 1'b0;
    for (int i = 0; i < NUM_LEVELS; i++) begin
      if (active_r[i] && LVL_W'(i) <= winLvl)
        blocked = 1'b1;
    end
  end

  always_comb begin
    pend_nxt = pend_r | levelReq;
    active_nxt = active_r;
    if (retValid)
      active_nxt[retLevel] = 1'b0;
    // a return and a take never share an edge, so the top sees every take it starts
    if (win && !blocked && !retValid) begin
      active_nxt[winLvl] = 1'b1;
      pend_nxt[winLvl] = levelReq[winLvl];
    end
    if (srst) begin
      pend_nxt = '0;
      active_nxt = ACTIVE_RST;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (clkEn || srst) begin
      pend_r <= pend_nxt;
      active_r <= active_nxt;
    end
  end

  assign pend = pend_r;
  assign active = active_r;
  assign take = win && !blocked && !retValid && !srst;
  assign takeLevel = winLvl;
endmodule

// ===== design/epc_event_priority_controller.sv
`timescale 1ns/100ps
module epc_event_priority_controller (
  input  wire logic                          sys_clk,
  input  wire logic                          srst,
  input  wire logic                          clkEn,
  input  wire logic                          emuReq,
  input  wire logic                          resetReq,
  input  wire logic                          watchdogNmi,
  input  wire logic                          nmiPin_n,
  input  wire logic                          excReq,
  input  wire logic                          hwErrReq,
  input  wire logic                          coreTmrReq,
  input  wire logic [epc_pkg::NUM_PERIPH-1:0] periphIrq,
  input  wire logic [1:0]                    swRaise,
  input  wire logic                          mapWrEn,
  input  wire logic [4:0]                    mapWrIdx,
  input  wire logic [epc_pkg::MAP_W-1:0]     mapWrVal,
  input  wire logic [epc_pkg::ADDR_W-1:0]    curPc,
  input  wire logic [epc_pkg::STATE_W-1:0]   curState,
  input  wire logic                          retValid,
  input  wire logic [epc_pkg::LVL_W-1:0]     retLevel,
  output logic                               emuMode,
  output logic                               procReset,
  output logic                               instrKill,
  output logic                               pushValid,
  output logic      [epc_pkg::STATE_W-1:0]   pushData,
  output logic                               vecValid,
  output logic      [epc_pkg::LVL_W-1:0]     vecLevel,
  output logic                               resumeValid,
  output logic      [epc_pkg::ADDR_W-1:0]    resumeAddr,
  output logic      [epc_pkg::NUM_LEVELS-1:0] activeLevels
);
  import epc_pkg::*;

  typedef struct packed {
    logic [2:0]                        nmiSync;
    logic                              nmiPrev;
    epc_fsm_t                          fsm;
    logic [1:0]                        cnt;
    logic [LVL_W-1:0]                  lvl;
    logic [ADDR_W-1:0]                 pcHold;
    logic [STATE_W-1:0]                stateHold;
    logic [NUM_LEVELS-1:0]             held;
    logic [NUM_LEVELS-1:0][ADDR_W-1:0] retAddr;
    logic                              emu;
    logic                              rstOut;
    logic                              kill;
    logic                              push;
    logic [STATE_W-1:0]                pushD;
    logic                              vec;
    logic [LVL_W-1:0]                  vecL;
    logic                              resume;
    logic [ADDR_W-1:0]                 resumeA;
    logic [NUM_LEVELS-1:0]             act;
  } epc_top_st_t;

  epc_top_st_t st_r;
  epc_top_st_t st_nxt;

  epc_route_if route ();

  logic [NUM_LEVELS-1:0] levelReq;
  logic [NUM_LEVELS-1:0] corePend;
  logic [NUM_LEVELS-1:0] coreActive;
  logic                  coreTake;
  logic [LVL_W-1:0]      coreLevel;
  logic                  nmiEdge;
  logic                  coreRet;
  logic [NUM_LEVELS-1:0] coreReq;

  epc_sys_stage u_sys (
    .sys_clk   (sys_clk),
    .srst      (srst),
    .clkEn     (clkEn),
    .periphIrq (periphIrq),
    .mapWrEn   (mapWrEn),
    .mapWrIdx  (mapWrIdx),
    .mapWrVal  (mapWrVal),
    .route     (route.stage)
  );

  // nmi pin is asynchronous: count once stages two and three agree on low
  assign nmiEdge = (!st_r.nmiSync[1] && !st_r.nmiSync[2] && st_r.nmiPrev) || watchdogNmi;

  always_comb begin
    levelReq = '0;
    levelReq[LVL_EMU] = emuReq;
    levelReq[LVL_RST] = resetReq;
    levelReq[LVL_NMI] = nmiEdge;
    levelReq[LVL_EXC] = excReq;
    levelReq[LVL_HWE] = hwErrReq;
    levelReq[LVL_TMR] = coreTmrReq;
    for (int g = 0; g < NUM_GP; g++)
      levelReq[GP_BASE+g] = route.core.gpReq[g];
    levelReq[SW_LVL_LO]   = levelReq[SW_LVL_LO] | swRaise[0];
    levelReq[SW_LVL_LO+1] = levelReq[SW_LVL_LO+1] | swRaise[1];
  end

  assign coreRet = retValid && st_r.fsm == EPC_IDLE;

  epc_core_stage u_core (
    .sys_clk   (sys_clk),
    .srst      (srst),
    .clkEn     (clkEn && (st_r.fsm == EPC_IDLE)),
    .levelReq  (coreReq),
    .retValid  (coreRet),
    .retLevel  (retLevel),
    .pend      (corePend),
    .active    (coreActive),
    .take      (coreTake),
    .takeLevel (coreLevel)
  );

  // the core stage is frozen during an entry; requests seen meanwhile wait here until idle
  assign coreReq = levelReq | st_r.held;

  always_comb begin
    st_nxt = st_r;
    st_nxt.nmiSync = {st_r.nmiSync[1:0], nmiPin_n};
    // filtered pin level follows only when stages two and three agree
    st_nxt.nmiPrev = (st_r.nmiSync[1] == st_r.nmiSync[2]) ? st_r.nmiSync[2] : st_r.nmiPrev;
    st_nxt.held = (st_r.fsm == EPC_IDLE) ? '0 : (st_r.held | levelReq);
    st_nxt.kill = 1'b0;
    st_nxt.push = 1'b0;
    st_nxt.vec = 1'b0;
    st_nxt.resume = 1'b0;
    st_nxt.rstOut = 1'b0;
    st_nxt.act = coreActive;
    unique case (st_r.fsm)
      EPC_IDLE: begin
        if (coreRet) begin
          st_nxt.resume = 1'b1;
          st_nxt.resumeA = st_r.retAddr[retLevel];
          if (retLevel == LVL_EMU)
            st_nxt.emu = 1'b0;
        end else if (coreTake) begin
          st_nxt.lvl = coreLevel;
          st_nxt.pcHold = curPc;
          st_nxt.stateHold = curState;
          st_nxt.kill = (coreLevel == LVL_EXC);
          st_nxt.cnt = '0;
          st_nxt.fsm = (coreLevel == LVL_RST) ? EPC_RESET : EPC_SAVE;
        end
      end
      EPC_SAVE: begin
        st_nxt.push = 1'b1;
        st_nxt.pushD = (st_r.cnt == 2'h0) ? st_r.stateHold : st_r.pcHold;
        st_nxt.cnt = st_r.cnt + 2'h1;
        if (st_r.cnt + 2'h1 == SAVE_CYCLES)
          st_nxt.fsm = EPC_ENTER;
      end
      EPC_ENTER: begin
        st_nxt.retAddr[st_r.lvl] = st_r.pcHold;
        st_nxt.vec = 1'b1;
        st_nxt.vecL = st_r.lvl;
        if (st_r.lvl == LVL_EMU)
          st_nxt.emu = 1'b1;
        st_nxt.fsm = EPC_IDLE;
      end
      EPC_RESET: begin
        st_nxt.rstOut = 1'b1;
        st_nxt.emu = 1'b0;
        st_nxt.fsm = EPC_ENTER;
      end
    endcase
    if (srst) begin
      st_nxt = '0;
      st_nxt.nmiSync = 3'h7;
      st_nxt.nmiPrev = 1'b1;
      st_nxt.fsm = EPC_IDLE;
      st_nxt.act = ACTIVE_RST;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (clkEn || srst)
      st_r <= st_nxt;
  end

  assign emuMode = st_r.emu;
  assign procReset = st_r.rstOut;
  assign instrKill = st_r.kill;
  assign pushValid = st_r.push;
  assign pushData = st_r.pushD;
  assign vecValid = st_r.vec;
  assign vecLevel = st_r.vecL;
  assign resumeValid = st_r.resume;
  assign resumeAddr = st_r.resumeA;
  assign activeLevels = st_r.act;
endmodule

// ===== sim/epc_assertions.sv
`timescale 1ns/100ps
module epc_assertions
  import epc_pkg::*;
(
  input wire logic                  sys_clk,
  input wire logic                  srst,
  input wire logic                  retValid,
  input wire logic                  instrKill,
  input wire logic                  pushValid,
  input wire logic                  vecValid,
  input wire logic [LVL_W-1:0]      vecLevel,
  input wire logic                  procReset,
  input wire logic                  resumeValid,
  input wire logic                  emuMode,
  input wire logic [NUM_LEVELS-1:0] activeLevels
);
  logic [NUM_LEVELS-1:0] aboveMask;

  assign aboveMask = (16'h1 << vecLevel) - 16'h1;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  rst_quiet_a: assert property (disable iff (1'b0) srst |=> !vecValid && !pushValid && !procReset)
    else $error("outputs busy after reset");
  exc_entry_a: assert property (instrKill |=> pushValid ##1 pushValid ##1 (vecValid && vecLevel == LVL_EXC))
    else $error("exception entry order wrong");
  kill_pulse_a: assert property (instrKill |=> !instrKill)
    else $error("kill longer than one cycle");
  push_pair_a: assert property ($rose(pushValid) |=> pushValid ##1 !pushValid)
    else $error("push not two beats");
  save_first_a: assert property (vecValid |-> $past(pushValid) || $past(procReset))
    else $error("vector before state save");
  rst_vec_a: assert property (procReset |=> vecValid && vecLevel == LVL_RST)
    else $error("reset vector missing");
  resume_cause_a: assert property (resumeValid |-> $past(retValid))
    else $error("resume without return");
  one_entry_a: assert property (vecValid |=> !vecValid)
    else $error("vector longer than one cycle");
  emu_entry_a: assert property (vecValid && vecLevel == LVL_EMU |-> emuMode)
    else $error("emulation mode not entered");
  nest_order_a: assert property (vecValid |-> activeLevels[vecLevel] && (activeLevels & aboveMask) == '0)
    else $error("vector while a more urgent handler is active");
  kill_c: cover property (instrKill);
  reset_c: cover property (procReset);
  resume_c: cover property (resumeValid);
  nest_c: cover property (vecValid && vecLevel == LVL_NMI && activeLevels[15:7] != '0);
endmodule

bind epc_event_priority_controller epc_assertions chk (.sys_clk(sys_clk), .srst(srst), .retValid(retValid),
  .instrKill(instrKill), .pushValid(pushValid), .vecValid(vecValid), .vecLevel(vecLevel),
  .procReset(procReset), .resumeValid(resumeValid), .emuMode(emuMode), .activeLevels(activeLevels));

// ===== sim/epc_periph_model.sv
`timescale 1ns/100ps
module epc_periph_model (
  input  wire logic        sys_clk,
  output logic      [31:0] periphIrq,
  output logic             watchdogNmi,
  output logic             nmiPin_n
);
  initial begin
    periphIrq = '0;
    watchdogNmi = 1'b0;
    nmiPin_n = 1'b1;
  end
  task automatic raise(input logic [4:0] src);
    @(negedge sys_clk) periphIrq[src] = 1'b1;
    @(negedge sys_clk) periphIrq = '0;
  endtask
  task automatic dogBite();
    @(negedge sys_clk) watchdogNmi = 1'b1;
    @(negedge sys_clk) watchdogNmi = 1'b0;
  endtask
  // pin held low long enough to pass the synchronizer
  task automatic pinNmi();
    @(negedge sys_clk) nmiPin_n = 1'b0;
    repeat (5) @(negedge sys_clk);
    nmiPin_n = 1'b1;
  endtask
endmodule

// ===== sim/event_priority_controller_bench.sv
`timescale 1ns/100ps
module event_priority_controller_bench;
  import epc_pkg::*;
  logic                  sys_clk = 1'b0;
  logic                  srst = 1'b1;
  logic [4:0]            reqVec = '0;
  logic [1:0]            swRaise = '0;
  logic                  mapWrEn = 1'b0;
  logic [4:0]            mapWrIdx = '0;
  logic [MAP_W-1:0]      mapWrVal = '0;
  logic [ADDR_W-1:0]     curPc = '0;
  logic [STATE_W-1:0]    curState = '0;
  logic                  retValid = 1'b0;
  logic [LVL_W-1:0]      retLevel = '0;
  logic [NUM_PERIPH-1:0] periphIrq;
  logic                  watchdogNmi;
  logic                  nmiPin_n;
  logic                  emuMode;
  logic                  pushValid;
  logic [STATE_W-1:0]    pushData;
  logic                  vecValid;
  logic [LVL_W-1:0]      vecLevel;
  logic                  resumeValid;
  logic [ADDR_W-1:0]     resumeAddr;
  logic                  procReset;
  logic                  instrKill;
  logic [NUM_LEVELS-1:0] activeLevels;
  logic [ADDR_W-1:0]     expRet[NUM_LEVELS];
  int                    kills = 0;
  int                    rsts = 0;
  logic [LVL_W-1:0]      expVec[$];
  logic [31:0]           expPush[$];
  logic [ADDR_W-1:0]     expRes[$];
  int                    fails = 0;
  int                    checksDone = 0;
  int                    cyc = 0;

  always #50 sys_clk = ~sys_clk;

  epc_periph_model peri (.sys_clk(sys_clk), .periphIrq(periphIrq), .watchdogNmi(watchdogNmi), .nmiPin_n(nmiPin_n));

  epc_event_priority_controller dut (.sys_clk(sys_clk), .srst(srst), .clkEn(1'b1), .emuReq(reqVec[4]),
    .resetReq(reqVec[3]), .watchdogNmi(watchdogNmi), .nmiPin_n(nmiPin_n), .excReq(reqVec[2]),
    .hwErrReq(reqVec[1]), .coreTmrReq(reqVec[0]), .periphIrq(periphIrq), .swRaise(swRaise),
    .mapWrEn(mapWrEn), .mapWrIdx(mapWrIdx), .mapWrVal(mapWrVal), .curPc(curPc), .curState(curState),
    .retValid(retValid), .retLevel(retLevel), .emuMode(emuMode), .procReset(procReset), .instrKill(instrKill),
    .pushValid(pushValid), .pushData(pushData), .vecValid(vecValid), .vecLevel(vecLevel),
    .resumeValid(resumeValid), .resumeAddr(resumeAddr), .activeLevels(activeLevels));

  task automatic chk(input bit ok, input string msg);
    checksDone++;
    if (!ok) begin
      fails++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checksDone, fails);
    if (fails == 0 && checksDone > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  function automatic logic [3:0] dmap(input logic [4:0] s);
    return s < 14 ? 4'h7 : s < 16 ? 4'h8 : s < 20 ? 4'h9 : s < 26 ? 4'ha : 4'hb;
  endfunction

  // a take pushes state then pc, except the reset entry; each entry sees fresh pc and state
  task automatic expectVec(input logic [LVL_W-1:0] lvl);
    curPc = $urandom();
    curState = $urandom();
    expRet[lvl] = curPc;
    expVec.push_back(lvl);
    if (lvl === LVL_EXC) kills++;
    if (lvl === LVL_RST) rsts++;
    else begin
      expPush.push_back(curState);
      expPush.push_back(curPc);
    end
  endtask

  task automatic fire(input logic [4:0] m);
    @(negedge sys_clk) reqVec = m;
    @(negedge sys_clk) reqVec = '0;
  endtask

  task automatic settle();
    int n = 0;
    while (expVec.size() != 0 && n < 300) begin
      @(negedge sys_clk);
      n++;
    end
    chk(expVec.size() == 0, "vector not taken");
    repeat (3) @(negedge sys_clk);
    chk(kills == 0 && rsts == 0, "side pulse missing");
  endtask

  task automatic ret(input logic [LVL_W-1:0] lvl);
    chk(activeLevels[lvl] === 1'b1, "level not active");
    expRes.push_back(expRet[lvl]);
    @(negedge sys_clk) retValid = 1'b1;
    retLevel = lvl;
    @(negedge sys_clk) retValid = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk(expRes.size() == 0, "no resume");
    chk(activeLevels[lvl] === 1'b0, "level still active");
  endtask

  always @(negedge sys_clk) begin
    if (srst === 1'b0 && pushValid === 1'b1)
      chk(expPush.size() != 0 && pushData === expPush.pop_front(), "push");
    if (srst === 1'b0 && vecValid === 1'b1)
      chk(expVec.size() != 0 && vecLevel === expVec.pop_front(), "vector");
    if (srst === 1'b0 && resumeValid === 1'b1)
      chk(expRes.size() != 0 && resumeAddr === expRes.pop_front(), "resume");
    if (srst === 1'b0 && instrKill === 1'b1) begin
      chk(kills > 0, "unexpected kill");
      kills--;
    end
    if (srst === 1'b0 && procReset === 1'b1) begin
      chk(rsts > 0, "unexpected processor reset");
      rsts--;
    end
  end

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      conclude();
    end
  end

  initial begin
    logic [4:0] src;
    void'($urandom(32'hc8fa));
    repeat (2) @(negedge sys_clk);
    srst = 1'b0;
    expectVec(LVL_EXC);
    fire(5'b00111);
    settle();
    expectVec(LVL_HWE);
    ret(LVL_EXC);
    settle();
    expectVec(LVL_TMR);
    ret(LVL_HWE);
    settle();
    ret(LVL_TMR);
    $display("test priority done");
    src = 5'($urandom_range(31, 0));
    expectVec(dmap(src));
    peri.raise(src);
    settle();
    expectVec(LVL_NMI);
    peri.dogBite();
    settle();
    ret(LVL_NMI);
    expectVec(LVL_NMI);
    peri.pinNmi();
    settle();
    ret(LVL_NMI);
    ret(dmap(src));
    $display("test nesting done");
    @(negedge sys_clk) mapWrEn = 1'b1;
    mapWrIdx = src;
    mapWrVal = 4'h8;
    @(negedge sys_clk) mapWrEn = 1'b0;
    expectVec(4'hf);
    peri.raise(src);
    settle();
    ret(4'hf);
    for (int i = 0; i < 2; i++) begin
      expectVec(4'(SW_LVL_LO + i));
      @(negedge sys_clk) swRaise = 2'(1 << i);
      @(negedge sys_clk) swRaise = '0;
      settle();
      ret(4'(SW_LVL_LO + i));
    end
    $display("test mapping done");
    expectVec(LVL_RST);
    fire(5'b01000);
    settle();
    expectVec(LVL_EMU);
    fire(5'b10000);
    settle();
    chk(emuMode === 1'b1, "emulation entry");
    ret(LVL_EMU);
    chk(emuMode === 1'b0, "emulation exit");
    @(negedge sys_clk) srst = 1'b1;
    repeat (2) @(negedge sys_clk);
    srst = 1'b0;
    @(negedge sys_clk);
    chk(activeLevels === ACTIVE_RST && emuMode === 1'b0, "state after reset");
    chk(expPush.size() == 0 && expRes.size() == 0, "notes left over");
    $display("test reset and emulation done");
    conclude();
  end
endmodule
